// ==== core/ips_sequencer.sv ====
// Power-on to user-mode sequencer for device I/O, with Wishbone slave.
// Assumes all inputs synchronous to clk_i; start-up clock rising edge detected against its registered copy.
`timescale 1ns/10ps
`include "ips_defines.svh"
module ips_sequencer #(
   parameter int            N        = 8,
   parameter int            NP       = 2,
   parameter logic [NP-1:0] DED_MASK = 2'h2,
   parameter int            INIT_NS  = `IPS_INIT_TIME_NS
)(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [31:0]      adr_i,
   input  wire logic [31:0]      dat_i,
   output      logic [31:0]      dat_o,
   input  wire logic             we_i,
   input  wire logic [3:0]       sel_i,
   input  wire logic             stb_i,
   input  wire logic             cyc_i,
   output      logic             ack_o,
   input  wire logic             bank2_supply_good_i,
   input  wire logic             core_supply_good_i,
   input  wire logic             aux_supply_good_i,
   input  wire logic             pullup_select_strap_i,
   input  wire logic             mode_select_bit0_i,
   input  wire logic             mode_select_bit1_i,
   input  wire logic             mode_select_bit2_i,
   input  wire logic             config_done_i,
   input  wire logic             startup_clk_i,
   input  wire logic [N-1:0]     user_oe_i,
   output      logic             init_status_o,
   output      logic             global_set_reset_net_o,
   output      logic             global_tristate_net_o,
   output      logic             global_write_enable_net_o,
   output      ips_pkg::ips_mode_t config_mode_o,
   output      logic             strap_gpio_en_o,
   output      logic [N-1:0]     io_oe_o,
   output      logic [N-1:0]     io_pullup_o,
   output      logic [N-1:0]     io_pulldown_o,
   output      logic [NP-1:0]    diff_term_o
);
   import ips_pkg::*;

   localparam int INIT_CYC = (INIT_NS + `IPS_CLK_PERIOD_NS - 1) / `IPS_CLK_PERIOD_NS;

   ips_state_t   state;
   ips_state_t   next_state;
   logic [15:0]  init_cnt;
   logic         su_q;
   logic         su_rise;
   logic         supplies_ok;
   logic         user_mode;
   ips_opt_t     opt;
   logic [N-1:0] pin_used;
   logic [N-1:0] user_pu;
   logic [N-1:0] user_pd;
   logic [NP-1:0] diff_req;
   logic         wb_req;
   logic         wb_wr;
   logic [31:0]  rd_mux;

   ips_term_if #(.N(N), .NP(NP)) tif ();

   // ----------------------------------------------------------------
   // Power-on reset and start-up clock edge
   // ----------------------------------------------------------------
   assign supplies_ok = bank2_supply_good_i & core_supply_good_i & aux_supply_good_i;
   assign su_rise     = startup_clk_i & ~su_q;
   assign user_mode   = (state == ST_USER);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         su_q <= 1'b0;
      else
         su_q <= startup_clk_i;
   end

   // ----------------------------------------------------------------
   // Sequence state machine
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         ST_POR:     if (supplies_ok) next_state = ST_INIT;
         ST_INIT:    if (init_cnt == 16'h0000) next_state = ST_SAMPLE;
         ST_SAMPLE:  next_state = ST_LOAD;
         ST_LOAD:    if (config_done_i) next_state = ST_REL_CLR;
         ST_REL_CLR: next_state = ST_REL_HIZ;
         ST_REL_HIZ: if (su_rise) next_state = ST_REL_WEN;
         ST_REL_WEN: if (su_rise) next_state = ST_USER;
         ST_USER:    next_state = ST_USER;
         default:    next_state = ST_POR;
      endcase
      if (!supplies_ok)
         next_state = ST_POR;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state <= ST_POR;
      else
         state <= next_state;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || state != ST_INIT)
         init_cnt <= 16'(INIT_CYC - 1);
      else if (init_cnt != 16'h0000)
         init_cnt <= init_cnt - 16'h0001;
   end

   // ----------------------------------------------------------------
   // Global nets, status pin and mode capture
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         global_set_reset_net_o    <= 1'b1;
         global_tristate_net_o     <= 1'b1;
         global_write_enable_net_o <= 1'b0;
      end
      else
      begin
         global_set_reset_net_o    <= next_state inside {ST_POR, ST_INIT, ST_SAMPLE,
                                                         ST_LOAD};
         global_tristate_net_o     <= next_state != ST_REL_WEN &&
                                      next_state != ST_USER;
         global_write_enable_net_o <= next_state == ST_USER;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         init_status_o <= 1'b0;
      else
         // Rises on the edge that captures the mode pins
         init_status_o <= !(next_state inside {ST_POR, ST_INIT, ST_SAMPLE});
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         config_mode_o <= 3'h0;
      else if (state == ST_SAMPLE)
         config_mode_o <= {mode_select_bit2_i, mode_select_bit1_i, mode_select_bit0_i};
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         strap_gpio_en_o <= 1'b0;
      else
         strap_gpio_en_o <= next_state == ST_USER;
   end

   // ----------------------------------------------------------------
   // Wishbone slave, one wait state
   // ----------------------------------------------------------------
   assign wb_req = cyc_i & stb_i & ~ack_o;
   assign wb_wr  = wb_req & we_i;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
      return r;
   endfunction : merge

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_o <= 1'b0;
      else
         ack_o <= wb_req;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         opt      <= 2'(`IPS_CTRL_RESET >> `IPS_CTRL_OPT_LSB);
         pin_used <= N'(`IPS_PINS_RESET);
         user_pu  <= N'(`IPS_PINS_RESET);
         user_pd  <= N'(`IPS_PINS_RESET);
         diff_req <= NP'(`IPS_PINS_RESET);
      end
      else if (wb_wr)
      begin
         case (adr_i[7:0])
            `IPS_ADDR_CTRL:
               opt <= 2'(merge(32'(opt), dat_i, sel_i) >> `IPS_CTRL_OPT_LSB);
            `IPS_ADDR_PIN_USED: pin_used <= N'(merge(32'(pin_used), dat_i, sel_i));
            `IPS_ADDR_USER_PU:  user_pu  <= N'(merge(32'(user_pu), dat_i, sel_i));
            `IPS_ADDR_USER_PD:  user_pd  <= N'(merge(32'(user_pd), dat_i, sel_i));
            `IPS_ADDR_DIFF_REQ: diff_req <= NP'(merge(32'(diff_req), dat_i, sel_i));
            default:            ;
         endcase
      end
   end

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (adr_i[7:0])
         `IPS_ADDR_CTRL:     rd_mux = 32'(opt) << `IPS_CTRL_OPT_LSB;
         `IPS_ADDR_STATUS:
         begin
            rd_mux[`IPS_ST_INIT_LSB]  = init_status_o;
            rd_mux[`IPS_ST_CLR_LSB]   = global_set_reset_net_o;
            rd_mux[`IPS_ST_HIZ_LSB]   = global_tristate_net_o;
            rd_mux[`IPS_ST_WEN_LSB]   = global_write_enable_net_o;
            rd_mux[`IPS_ST_STRAP_LSB] = pullup_select_strap_i;
            rd_mux[`IPS_ST_USER_LSB]  = user_mode;
            rd_mux[`IPS_ST_MODE_LSB +: 3]  = config_mode_o;
            rd_mux[`IPS_ST_STATE_LSB +: 4] = state;
         end
         `IPS_ADDR_PIN_USED: rd_mux = 32'(pin_used);
         `IPS_ADDR_USER_PU:  rd_mux = 32'(user_pu);
         `IPS_ADDR_USER_PD:  rd_mux = 32'(user_pd);
         `IPS_ADDR_DIFF_REQ: rd_mux = 32'(diff_req);
         default:            rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_o <= 32'h0000_0000;
      else if (wb_req)
         dat_o <= rd_mux;
   end

   // ----------------------------------------------------------------
   // Pin termination
   // ----------------------------------------------------------------
   assign tif.user_mode = user_mode;
   assign tif.global_tristate_net       = global_tristate_net_o;
   assign tif.strap     = pullup_select_strap_i;
   assign tif.opt       = opt;
   assign tif.used      = pin_used;
   assign tif.user_pu   = user_pu;
   assign tif.user_pd   = user_pd;
   assign tif.user_oe   = user_oe_i;
   assign tif.diff_req  = diff_req;

   ips_pin_term #(.N(N), .NP(NP), .DED_MASK(DED_MASK)) u_term (.t(tif.term));

   assign io_oe_o       = tif.oe;
   assign io_pullup_o   = tif.pu;
   assign io_pulldown_o = tif.pd;
   assign diff_term_o   = tif.diff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_drivers_off: assert property (global_tristate_net_o |-> io_oe_o == '0)
      else $error("driver enabled while tristate net held");
   a_por_inputs: assert property (!supplies_ok |=> state == ST_POR && global_set_reset_net_o)
      else $error("supply loss did not return to power-on reset");
   a_strap_pullups: assert property (
      !user_mode && !pullup_select_strap_i |-> io_pullup_o == '1 && io_pulldown_o == '0)
      else $error("strap low but pull-ups missing");
   a_strap_float: assert property (
      !user_mode && pullup_select_strap_i |-> io_pullup_o == '0 && io_pulldown_o == '0)
      else $error("strap high but pins not floating");
   a_init_holds_clr: assert property (
      state == ST_INIT |=> global_set_reset_net_o && !init_status_o || state != ST_INIT)
      else $error("set/reset or status wrong during init");
   a_mode_sample: assert property (
      state == ST_SAMPLE |=> init_status_o && config_mode_o == {$past(mode_select_bit2_i),
      $past(mode_select_bit1_i), $past(mode_select_bit0_i)})
      else $error("mode not sampled with status pin rise");
   a_clr_release: assert property (
      $fell(global_set_reset_net_o) |-> $past(state) == ST_LOAD && $past(config_done_i))
      else $error("set/reset released outside configuration end");
   a_hiz_release: assert property (
      $fell(global_tristate_net_o) |-> $past(su_rise) && !global_set_reset_net_o)
      else $error("tristate released off a start-up edge");
   a_wen_after_hiz: assert property (
      $rose(global_write_enable_net_o) |-> $past(su_rise) && $past(state) == ST_REL_WEN
      && !$past(global_tristate_net_o))
      else $error("write enable not one start-up cycle after tristate");
   a_unused_default: assert property (
      user_mode && !pin_used[N-1] && opt == `IPS_OPT_PULLDOWN
      |-> io_pulldown_o[N-1] && !io_pullup_o[N-1])
      else $error("unused pin not pulled down");
   a_unused_option: assert property (
      user_mode && !pin_used[N-1] && opt == `IPS_OPT_FLOAT
      |-> !io_pulldown_o[N-1] && !io_pullup_o[N-1])
      else $error("unused pin float option ignored");
   a_strap_gpio: assert property (strap_gpio_en_o == user_mode)
      else $error("strap pin freed outside user mode");
   a_no_ded_term: assert property ((diff_term_o & DED_MASK) == '0)
      else $error("termination on dedicated input pair");
   a_order: assert property (
      state == ST_REL_WEN |-> $past(state) inside {ST_REL_HIZ, ST_REL_WEN})
      else $error("sequence stage skipped");

   c_reach_user:   cover property ($rose(user_mode));
   c_supply_drop:  cover property (state == ST_LOAD ##1 state == ST_POR);
   c_strap_low:    cover property (!pullup_select_strap_i && state == ST_LOAD);
   c_wb_write:     cover property (wb_wr && adr_i[7:0] == `IPS_ADDR_CTRL);

endmodule : ips_sequencer

// ==== core/ips_defines.svh ====
// Constants of the I/O power-up and configuration sequencer.
// Assumes a 50 MHz system clock and a classic Wishbone register bus.
//
// Behaviour
// - Drivers high impedance once three supplies good.
// - Power-on reset takes bank2, core, aux supply-good.
// - Strap low enables pull-ups until user mode.
// - Strap high floats pins; open strap reads high.
// - At power, initialize and hold set/reset asserted.
// - Init done: status pin high, sample mode bits.
// - Loading keeps drivers off, pull-ups per strap.
// - Configuration end releases set/reset net.
// - Start-up releases tristate net; user mode waits for write-enable.
// - Unused pins default to weak pull-down.
// - Option selects unused termination: up, down, float.
// - Write-enable released one start-up cycle later.
// - User mode: design pulls replace strap pull-ups.
// - Input-only and idle dual pins behave alike.
// - Dedicated input pairs never get differential termination.
`ifndef IPS_DEFINES_SVH
`define IPS_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define IPS_ADDR_CTRL      8'h00
`define IPS_ADDR_STATUS    8'h04
`define IPS_ADDR_PIN_USED  8'h08
`define IPS_ADDR_USER_PU   8'h0C
`define IPS_ADDR_USER_PD   8'h10
`define IPS_ADDR_DIFF_REQ  8'h14

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define IPS_CTRL_OPT_LSB   0
`define IPS_CTRL_RESET     32'h0000_0000
`define IPS_PINS_RESET     32'h0000_0000
`define IPS_OPT_PULLDOWN   2'h0
`define IPS_OPT_PULLUP     2'h1
`define IPS_OPT_FLOAT      2'h2
`define IPS_ST_INIT_LSB    0
`define IPS_ST_CLR_LSB     1
`define IPS_ST_HIZ_LSB     2
`define IPS_ST_WEN_LSB     3
`define IPS_ST_STRAP_LSB   4
`define IPS_ST_USER_LSB    5
`define IPS_ST_MODE_LSB    8
`define IPS_ST_STATE_LSB   16

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IPS_CLK_PERIOD_NS  20
`define IPS_INIT_TIME_NS   1000

`endif

// ==== core/ips_pkg.sv ====
// Types of the I/O power-up and configuration sequencer.
// Assumes ips_defines.svh holds all numeric constants.
package ips_pkg;

   typedef enum logic [3:0]
   {
      ST_POR,
      ST_INIT,
      ST_SAMPLE,
      ST_LOAD,
      ST_REL_CLR,
      ST_REL_HIZ,
      ST_REL_WEN,
      ST_USER
   } ips_state_t;

   typedef logic [2:0] ips_mode_t;
   typedef logic [1:0] ips_opt_t;

endpackage : ips_pkg

// ==== core/ips_term_if.sv ====
// Signals between the sequencer and its pin termination logic.
// Assumes both ends share clk_i domain; the interface is purely combinational.
`timescale 1ns/10ps
interface ips_term_if #(parameter int N = 8, parameter int NP = 2);
   logic                     user_mode;
   logic                     global_tristate_net;
   logic                     strap;
   ips_pkg::ips_opt_t        opt;
   logic [N-1:0]             used;
   logic [N-1:0]             user_pu;
   logic [N-1:0]             user_pd;
   logic [N-1:0]             user_oe;
   logic [NP-1:0]            diff_req;
   logic [N-1:0]             pu;
   logic [N-1:0]             pd;
   logic [N-1:0]             oe;
   logic [NP-1:0]            diff;

   modport seq  (output user_mode, global_tristate_net, strap, opt, used, user_pu, user_pd, user_oe,
                 diff_req, input pu, pd, oe, diff);
   modport term (input user_mode, global_tristate_net, strap, opt, used, user_pu, user_pd, user_oe,
                 diff_req, output pu, pd, oe, diff);
endinterface : ips_term_if

// ==== core/ips_pin_term.sv ====
// Per-pin pull, drive and differential termination control.
// Assumes phase inputs come from the sequencer through ips_term_if.
`timescale 1ns/10ps
`include "ips_defines.svh"
module ips_pin_term #(
   parameter int          N        = 8,
   parameter int          NP       = 2,
   parameter logic [NP-1:0] DED_MASK = '0
)(
   ips_term_if.term t
);
   import ips_pkg::*;

   // ----------------------------------------------------------------
   // Per-pin termination, same for I/O and input-only pins
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < N; i++)
      begin : g_pin
         always_comb
         begin
            t.pu[i] = 1'b0;
            t.pd[i] = 1'b0;
            if (!t.user_mode)
            begin
               t.pu[i] = !t.strap;
            end
            else if (t.used[i])
            begin
               t.pu[i] = t.user_pu[i];
               t.pd[i] = t.user_pd[i] & ~t.user_pu[i];
            end
            else
            begin
               case (t.opt)
                  `IPS_OPT_PULLUP:   t.pu[i] = 1'b1;
                  `IPS_OPT_FLOAT:    t.pd[i] = 1'b0;
                  default:           t.pd[i] = 1'b1;
               endcase
            end
         end
         assign t.oe[i] = !t.global_tristate_net & t.used[i] & t.user_oe[i];
      end
      for (i = 0; i < NP; i++)
      begin : g_pair
         assign t.diff[i] = t.user_mode & t.diff_req[i] & !DED_MASK[i];
      end
   endgenerate

endmodule : ips_pin_term

// ==== tb/ips_board.sv ====
// Far-side model: supply monitors, strap and mode pins, configuration source
// and start-up clock. Assumes one shared clk_i; all outputs change after a rising edge.
`timescale 1ns/10ps
module ips_board
(
   input  wire logic       clk_i,
   output      logic       bank2_supply_good_o,
   output      logic       core_supply_good_o,
   output      logic       aux_supply_good_o,
   output      logic       pullup_select_strap_o,
   output      logic [2:0] mode_select_o,
   output      logic       config_done_o,
   output      logic       startup_clk_o
);
   // ----------------------------------------------------------------
   // Power-on pin state
   // ----------------------------------------------------------------
   initial
   begin
      {bank2_supply_good_o, core_supply_good_o, aux_supply_good_o} = 3'h0;
      pullup_select_strap_o = 1'b1;
      mode_select_o = 3'h0;
      config_done_o = 1'b0;
      startup_clk_o = 1'b0;
   end

   // ----------------------------------------------------------------
   // Commands from the bench
   // ----------------------------------------------------------------
   task automatic supplies(input logic [2:0] good);
      @(posedge clk_i);
      {bank2_supply_good_o, core_supply_good_o, aux_supply_good_o} <= good;
   endtask : supplies

   task automatic straps(input logic strap, input logic [2:0] mode);
      @(posedge clk_i);
      pullup_select_strap_o <= strap;
      mode_select_o <= mode;
   endtask : straps

   // Delay sets a prompt or a slow configuration source
   task automatic load_done(input logic v, input int delay);
      repeat (delay + 1) @(posedge clk_i);
      config_done_o <= v;
   endtask : load_done

   // Start-up clock stands low outside a single tick
   task automatic startup_tick;
      @(posedge clk_i);
      startup_clk_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      startup_clk_o <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : startup_tick
endmodule : ips_board

// ==== tb/io_powerup_config_sequencer_tb.sv ====
// Self-checking bench for the I/O power-up and configuration sequencer.
// Assumes ips_board models the far side; this module masters Wishbone.
`timescale 1ns/10ps
`define CHK(what, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         err_total++; \
         $display("MISMATCH %s expected %h seen %h", what, exp, got); \
      end \
   end
module io_powerup_config_sequencer_tb;
   import ips_pkg::*;
   logic        clk_i, rst_i, we_i, stb_i, cyc_i, ack_o;
   logic [31:0] adr_i, dat_i, dat_o, rd;
   logic [3:0]  sel_i;
   logic        bank2_supply_good_i, core_supply_good_i, aux_supply_good_i;
   logic        pullup_select_strap_i, config_done_i, startup_clk_i;
   logic [2:0]  mode_pins;
   logic [7:0]  user_oe_i, io_oe_o, io_pullup_o, io_pulldown_o;
   logic        init_status_o, global_set_reset_net_o, global_tristate_net_o;
   logic        global_write_enable_net_o, strap_gpio_en_o;
   ips_mode_t   config_mode_o;
   logic [1:0]  diff_term_o;
   int          err_total, samples_checked, wait_n;

   // ----------------------------------------------------------------
   // Design and far side
   // ----------------------------------------------------------------
   ips_sequencer #(.INIT_NS(100)) uut
   (
      .clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .stb_i, .cyc_i, .ack_o,
      .bank2_supply_good_i, .core_supply_good_i, .aux_supply_good_i, .pullup_select_strap_i,
      .mode_select_bit0_i(mode_pins[0]), .mode_select_bit1_i(mode_pins[1]),
      .mode_select_bit2_i(mode_pins[2]), .config_done_i, .startup_clk_i, .user_oe_i,
      .init_status_o, .global_set_reset_net_o, .global_tristate_net_o,
      .global_write_enable_net_o, .config_mode_o, .strap_gpio_en_o, .io_oe_o,
      .io_pullup_o, .io_pulldown_o, .diff_term_o
   );

   ips_board board
   (
      .clk_i, .bank2_supply_good_o(bank2_supply_good_i),
      .core_supply_good_o(core_supply_good_i), .aux_supply_good_o(aux_supply_good_i),
      .pullup_select_strap_o(pullup_select_strap_i), .mode_select_o(mode_pins),
      .config_done_o(config_done_i), .startup_clk_o(startup_clk_i)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // ----------------------------------------------------------------
   // Bus and check helpers
   // ----------------------------------------------------------------
`define WAIT(cond) \
   begin \
      wait_n = 0; \
      while (!(cond) && wait_n < 40) \
      begin \
         @(negedge clk_i); \
         wait_n++; \
      end \
      if (!(cond)) \
         fail_out(); \
   end

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict

   task automatic fail_out;
      err_total++;
      print_verdict();
   endtask : fail_out

   task automatic do_reset;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask : do_reset

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     input logic [3:0] s = 4'hF);
      int n;
      @(posedge clk_i);
      adr_i <= {24'h00_0000, a};
      dat_i <= wd;
      we_i <= w;
      sel_i <= s;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1)
         fail_out();
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask : wb

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000);
      `CHK("register read", exp, rd)
   endtask : rchk

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      logic [7:0] adr_tab [6];
      adr_tab = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
      @(negedge clk_i);
      `CHK("set/reset net", 1'b1, global_set_reset_net_o)
      `CHK("tristate net", 1'b1, global_tristate_net_o)
      `CHK("write enable net", 1'b0, global_write_enable_net_o)
      `CHK("oe", 8'h00, io_oe_o)
      `CHK("pullup", 8'h00, io_pullup_o)
      foreach (adr_tab[i])
         rchk(adr_tab[i], 32'h0000_0000);
      rchk(8'h04, 32'h0000_0016);
      wb(1'b1, 8'h18, 32'hFFFF_FFFF);
      rchk(8'h18, 32'h0000_0000);
      $display("test reset done");
   endtask : t_reset

   task automatic t_partial;
      board.straps(1'b0, 3'h5);
      for (int i = 0; i < 3; i++)
      begin
         board.supplies(3'h7 ^ (3'h1 << i));
         repeat (15) @(negedge clk_i);
         `CHK("init partial", 1'b0, init_status_o)
         `CHK("pullup partial", 8'hFF, io_pullup_o)
      end
      board.supplies(3'h0);
      $display("test partial supplies done");
   endtask : t_partial

   task automatic t_full;
      wb(1'b1, 8'h08, 32'h0000_000F);
      wb(1'b1, 8'h0C, 32'h0000_0003);
      wb(1'b1, 8'h0C, 32'h0000_00FF, 4'hE);
      wb(1'b1, 8'h10, 32'h0000_0006);
      wb(1'b1, 8'h14, 32'h0000_0003);
      board.supplies(3'h7);
      board.load_done(1'b1, 0);
      board.load_done(1'b0, 1);
      board.startup_tick();
      `WAIT(init_status_o === 1'b1)
      `CHK("mode", 3'h5, config_mode_o)
      repeat (5) @(negedge clk_i);
      `CHK("set/reset early done", 1'b1, global_set_reset_net_o)
      `CHK("tristate early tick", 1'b1, global_tristate_net_o)
      `CHK("oe load", 8'h00, io_oe_o)
      `CHK("pullup load", 8'hFF, io_pullup_o)
      board.load_done(1'b1, 30);
      `WAIT(global_set_reset_net_o === 1'b0)
      `CHK("tristate after set/reset", 1'b1, global_tristate_net_o)
      board.startup_tick();
      @(negedge clk_i);
      `CHK("tristate", 1'b0, global_tristate_net_o)
      `CHK("oe user", 8'h0A, io_oe_o)
      @(posedge clk_i);
      user_oe_i <= 8'hA5;
      @(negedge clk_i);
      `CHK("oe request", 8'h05, io_oe_o)
      repeat (10) @(negedge clk_i);
      `CHK("write enable held", 1'b0, global_write_enable_net_o)
      board.startup_tick();
      @(negedge clk_i);
      `CHK("write enable", 1'b1, global_write_enable_net_o)
      `CHK("strap gpio", 1'b1, strap_gpio_en_o)
      `CHK("pullup user", 8'h03, io_pullup_o)
      `CHK("pulldown user", 8'hF4, io_pulldown_o)
      `CHK("diff term", 2'h1, diff_term_o)
      wb(1'b1, 8'h04, 32'hFFFF_FFFF);
      rchk(8'h04, 32'h0007_0529);
      for (int o = 1; o < 3; o++)
      begin
         wb(1'b1, 8'h00, 32'(o));
         @(negedge clk_i);
         `CHK("pullup option", (o == 1) ? 8'hF3 : 8'h03, io_pullup_o)
         `CHK("pulldown option", 8'h04, io_pulldown_o)
      end
      board.supplies(3'h5);
      `WAIT(init_status_o === 1'b0)
      `CHK("tristate loss", 1'b1, global_tristate_net_o)
      `CHK("oe loss", 8'h00, io_oe_o)
      `CHK("set/reset loss", 1'b1, global_set_reset_net_o)
      board.load_done(1'b0, 0);
      board.supplies(3'h0);
      $display("test full sequence done");
   endtask : t_full

   task automatic t_strap_high;
      do_reset();
      board.straps(1'b1, 3'h2);
      board.supplies(3'h7);
      `WAIT(init_status_o === 1'b1)
      `CHK("mode", 3'h2, config_mode_o)
      `CHK("pullup strap high", 8'h00, io_pullup_o)
      `CHK("oe strap high", 8'h00, io_oe_o)
      $display("test strap high done");
   endtask : t_strap_high

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {rst_i, we_i, stb_i, cyc_i} = 4'h8;
      adr_i = 32'h0000_0000;
      dat_i = 32'h0000_0000;
      sel_i = 4'h0;
      user_oe_i = 8'h5A;
      do_reset();
      t_reset();
      t_partial();
      t_full();
      t_strap_high();
      print_verdict();
   end

   initial
   begin
      repeat (20000) @(posedge clk_i);
      fail_out();
   end
endmodule : io_powerup_config_sequencer_tb
